// >>> design/lighting_dimming_output_ctrl.sv
/*
 * Dimming output controller: three staggered 12-bit PWMs from a 10-bit
 * dimming level, strapped output mode, mains sync with long-low reset,
 * converter result hand-off and aux occupancy input.
 * Assumes a 40 MHz core clock and a plain register port on that clock;
 * pins and the analog converters' outputs are asynchronous.
 */
`timescale 1ns/1ps
module lighting_dimming_output_ctrl #(
    parameter int unsigned RESET_HOLD_CYC = dim_ctrl_pkg::RESET_HOLD_CYC,
    parameter int unsigned SYNC_IDLE_CYC = dim_ctrl_pkg::SYNC_IDLE_CYC
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [15:0] reg_rdata_o,
    input wire logic [1:0] mode_strap_i,
    input wire logic mains_lock_and_reset_pin_i,
    input wire logic [9:0] analog_dimmer_input_i,
    input wire logic hv_supply_in_range_i,
    input wire logic adc_done_i,
    input wire logic [47:0] adc_raw_i,
    input wire logic aux_digital_i,
    input wire logic [9:0] aux_analog_i,
    input wire logic [1:0] string_cct_i,
    output logic primary_dim_output_pin_o,
    output logic [11:0] primary_analog_level_o,
    output logic primary_analog_en_o,
    output logic tune_a_pwm_o,
    output logic tune_b_pwm_o,
    output logic internal_divider_sel_o,
    output logic device_reset_o
);
    localparam int unsigned RST_W = $clog2(RESET_HOLD_CYC + 1);
    localparam int unsigned IDLE_W = $clog2(SYNC_IDLE_CYC + 1);

    // ==========================================================
    // Input synchronisers
    logic sync_pin_m_q, sync_pin_q, sync_pin_d1_q;
    logic aux_m_q, aux_q, hv_m_q, hv_q, done_m_q, done_q, done_d1_q;
    logic [9:0] dim_m_q, dim_q, auxa_m_q, auxa_q;
    logic [1:0] cct_m_q, cct_q;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            sync_pin_m_q <= 1'b1;
            sync_pin_q <= 1'b1;
            aux_m_q <= 1'b0;
            aux_q <= 1'b0;
            hv_m_q <= 1'b0;
            hv_q <= 1'b0;
            done_m_q <= 1'b0;
            done_q <= 1'b0;
            dim_m_q <= '0;
            dim_q <= '0;
            auxa_m_q <= '0;
            auxa_q <= '0;
            cct_m_q <= '0;
            cct_q <= '0;
        end else if (ce_i) begin
            sync_pin_m_q <= mains_lock_and_reset_pin_i;
            sync_pin_q <= sync_pin_m_q;
            aux_m_q <= aux_digital_i;
            aux_q <= aux_m_q;
            hv_m_q <= hv_supply_in_range_i;
            hv_q <= hv_m_q;
            done_m_q <= adc_done_i;
            done_q <= done_m_q;
            dim_m_q <= analog_dimmer_input_i;
            dim_q <= dim_m_q;
            auxa_m_q <= aux_analog_i;
            auxa_q <= auxa_m_q;
            cct_m_q <= string_cct_i;
            cct_q <= cct_m_q;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            sync_pin_d1_q <= 1'b1;
            done_d1_q <= 1'b0;
        end else if (ce_i) begin
            sync_pin_d1_q <= sync_pin_q;
            done_d1_q <= done_q;
        end
    end

    // ==========================================================
    // Mode strap caught on the first enabled cycle after reset
    logic strap_taken_q;
    dim_ctrl_pkg::out_mode_t mode_q;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            strap_taken_q <= 1'b0;
            mode_q <= dim_ctrl_pkg::MODE_ANALOG;
        end else if (ce_i && !strap_taken_q) begin
            strap_taken_q <= 1'b1;
            case (mode_strap_i)
                2'h0: mode_q <= dim_ctrl_pkg::MODE_ANALOG;
                2'h1: mode_q <= dim_ctrl_pkg::MODE_DIGITAL;
                default: mode_q <= dim_ctrl_pkg::MODE_TUNE_ONLY;
            endcase
        end
    end

    // ==========================================================
    // Registers
    logic [7:0] ctrl_q;
    logic [15:0] period_q;
    logic [9:0] net_dim_q;
    logic wr_ok;
    assign wr_ok = ce_i && reg_wr_i;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            ctrl_q <= dim_ctrl_pkg::CTRL_RESET;
            period_q <= dim_ctrl_pkg::PERIOD_DEFAULT;
            net_dim_q <= dim_ctrl_pkg::NET_DIM_RESET;
        end else if (wr_ok) begin
            case (reg_addr_i)
                dim_ctrl_pkg::REG_CTRL: ctrl_q <= reg_wdata_i[7:0];
                dim_ctrl_pkg::REG_PERIOD: period_q <= (reg_wdata_i < dim_ctrl_pkg::PERIOD_MIN)
                    ? dim_ctrl_pkg::PERIOD_MIN : reg_wdata_i;
                dim_ctrl_pkg::REG_NET_DIM: net_dim_q <= reg_wdata_i[9:0];
                default: ;
            endcase
        end
    end

    // ==========================================================
    // 16 MHz master tick
    logic [3:0] acc_q;
    logic tick_q;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            acc_q <= '0;
            tick_q <= 1'b0;
        end else if (ce_i) begin
            if (acc_q + dim_ctrl_pkg::TICK_NUM >= dim_ctrl_pkg::TICK_DEN) begin
                acc_q <= acc_q + dim_ctrl_pkg::TICK_NUM - dim_ctrl_pkg::TICK_DEN;
                tick_q <= 1'b1;
            end else begin
                acc_q <= acc_q + dim_ctrl_pkg::TICK_NUM;
                tick_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Sync pin: presence detect and long-low reset
    logic [IDLE_W-1:0] idle_cnt_q;
    logic sync_live_q;
    logic [RST_W-1:0] low_cnt_q;
    logic sync_rise;
    assign sync_rise = sync_pin_q && !sync_pin_d1_q;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            idle_cnt_q <= '0;
            sync_live_q <= 1'b0;
        end else if (ce_i) begin
            if (sync_rise) begin
                idle_cnt_q <= '0;
                sync_live_q <= 1'b1;
            end else if (idle_cnt_q == IDLE_W'(SYNC_IDLE_CYC)) begin
                sync_live_q <= 1'b0;
            end else begin
                idle_cnt_q <= idle_cnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            low_cnt_q <= '0;
            device_reset_o <= 1'b0;
        end else if (ce_i) begin
            if (sync_pin_q) begin
                low_cnt_q <= '0;
                device_reset_o <= 1'b0;
            end else if (low_cnt_q == RST_W'(RESET_HOLD_CYC)) begin
                device_reset_o <= 1'b1;
            end else begin
                low_cnt_q <= low_cnt_q + 1'b1;
            end
        end
    end

    // ==========================================================
    // Dimming level and duty
    logic [9:0] dim_level;
    logic aux_occupied;
    logic [11:0] duty_raw, duty1;
    assign aux_occupied = ctrl_q[dim_ctrl_pkg::CTRL_AUX_DIG] ? aux_q
        : (auxa_q >= dim_ctrl_pkg::AUX_ANALOG_THRESH);
    always_comb begin
        dim_level = ctrl_q[dim_ctrl_pkg::CTRL_SRC_NET] ? net_dim_q : dim_q;
        if (ctrl_q[dim_ctrl_pkg::CTRL_AUX_CTL] && !aux_occupied) begin
            dim_level = '0;
        end
    end
    assign duty_raw = {dim_level, dim_level[9:8]};

    always_comb begin
        duty1 = duty_raw;
        if (mode_q == dim_ctrl_pkg::MODE_ANALOG && duty_raw < dim_ctrl_pkg::DUTY_MIN_ANALOG) begin
            duty1 = dim_ctrl_pkg::DUTY_MIN_ANALOG;
        end else if (duty_raw < dim_ctrl_pkg::DUTY_MIN_DIGITAL) begin
            duty1 = dim_ctrl_pkg::DUTY_MIN_DIGITAL;
        end
    end

    // ==========================================================
    // Period counter, restarted by sync edges
    logic [15:0] per_cnt_q;
    logic [11:0] duty_q [dim_ctrl_pkg::N_PWM];

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            per_cnt_q <= '0;
        end else if (ce_i) begin
            if (ctrl_q[dim_ctrl_pkg::CTRL_SYNC_EN] && sync_live_q && sync_rise) begin
                per_cnt_q <= '0;
            end else if (tick_q) begin
                if (per_cnt_q >= period_q - 1'b1) begin
                    per_cnt_q <= '0;
                end else begin
                    per_cnt_q <= per_cnt_q + 1'b1;
                end
            end
        end
    end

    logic [15:0] pos [dim_ctrl_pkg::N_PWM];
    logic [dim_ctrl_pkg::N_PWM-1:0] pwm_q;

    // Each channel runs STAGGER_TICKS further ahead in phase, so the channels' wrap edges never coincide
    genvar g;
    generate
        for (g = 0; g < dim_ctrl_pkg::N_PWM; g++) begin : g_ch
            logic [16:0] shifted;
            logic [27:0] thr_full;
            logic [15:0] thr;
            assign shifted = {1'b0, per_cnt_q} + 17'(dim_ctrl_pkg::STAGGER_TICKS * g);
            assign pos[g] = (shifted >= {1'b0, period_q}) ? 16'(shifted - {1'b0, period_q})
                : shifted[15:0];
            // Compare threshold: duty scaled onto the period
            assign thr_full = period_q * duty_q[g];
            assign thr = (duty_q[g] == dim_ctrl_pkg::DUTY_FULL) ? period_q
                : thr_full[27:12];
            // New duty taken at this channel's own wrap, so a level change stays staggered
            always_ff @(posedge core_clk_i) begin
                if (rst_i) begin
                    duty_q[g] <= '0;
                    pwm_q[g] <= 1'b0;
                end else if (ce_i) begin
                    if (tick_q && pos[g] >= period_q - 1'b1) begin
                        duty_q[g] <= duty_raw;
                    end
                    pwm_q[g] <= pos[g] < thr;
                end
            end
        end
    endgenerate

    // ==========================================================
    // Output steering
    logic swap;
    assign swap = ctrl_q[dim_ctrl_pkg::CTRL_SWAP] ^ cct_q[0] ^ cct_q[1];

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            primary_dim_output_pin_o <= 1'b0;
            primary_analog_level_o <= '0;
            primary_analog_en_o <= 1'b0;
            tune_a_pwm_o <= 1'b0;
            tune_b_pwm_o <= 1'b0;
            internal_divider_sel_o <= 1'b0;
        end else if (ce_i && strap_taken_q) begin
            internal_divider_sel_o <= hv_q;
            tune_a_pwm_o <= swap ? pwm_q[2] : pwm_q[1];
            tune_b_pwm_o <= swap ? pwm_q[1] : pwm_q[2];
            case (mode_q)
                dim_ctrl_pkg::MODE_ANALOG: begin
                    primary_dim_output_pin_o <= 1'b0;
                    primary_analog_level_o <= duty1;
                    primary_analog_en_o <= 1'b1;
                end
                dim_ctrl_pkg::MODE_DIGITAL: begin
                    primary_dim_output_pin_o <= (duty1 == duty_raw) ? pwm_q[0]
                        : (pos[0] < 16'((32'(period_q) * 32'(duty1)) >> 12));
                    primary_analog_level_o <= '0;
                    primary_analog_en_o <= 1'b0;
                end
                default: begin
                    primary_dim_output_pin_o <= 1'b0;
                    primary_analog_level_o <= '0;
                    primary_analog_en_o <= 1'b0;
                end
            endcase
        end
    end

    // ==========================================================
    // Converter hand-off and read port
    adc_bank_if abus ();
    assign abus.done = done_q && !done_d1_q;
    assign abus.raw[0] = adc_raw_i[15:0];
    assign abus.raw[1] = adc_raw_i[31:16];
    assign abus.raw[2] = adc_raw_i[47:32];
    assign abus.rd_sel = 2'(reg_addr_i - dim_ctrl_pkg::REG_ADC_X);

    adc_result_bank u_bank (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .bus(abus.bank)
    );

    logic rd_adc_q;
    logic [15:0] rd_reg_q;
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            rd_adc_q <= 1'b0;
            rd_reg_q <= '0;
        end else if (ce_i) begin
            rd_adc_q <= reg_rd_i && reg_addr_i >= dim_ctrl_pkg::REG_ADC_X
                && reg_addr_i <= dim_ctrl_pkg::REG_ADC_Z;
            case (reg_addr_i)
                dim_ctrl_pkg::REG_CTRL: rd_reg_q <= {8'h00, ctrl_q};
                dim_ctrl_pkg::REG_PERIOD: rd_reg_q <= period_q;
                dim_ctrl_pkg::REG_NET_DIM: rd_reg_q <= {6'h00, net_dim_q};
                dim_ctrl_pkg::REG_STATUS: rd_reg_q <= {9'h000, hv_q, aux_occupied,
                    sync_live_q, strap_taken_q, 1'b0, mode_q};
                dim_ctrl_pkg::REG_DUTY1: rd_reg_q <= {4'h0, duty1};
                dim_ctrl_pkg::REG_STRING: rd_reg_q <= {15'h0000, swap};
                default: rd_reg_q <= '0;
            endcase
        end
    end
    assign reg_rdata_o = rd_adc_q ? abus.rd_data : rd_reg_q;
endmodule // lighting_dimming_output_ctrl

// >>> design/dim_ctrl_pkg.sv
/*
 * Constants shared by the dimming output controller: register map,
 * output modes, PWM timing and the sync/reset filter times.
 * Assumes a 40 MHz core clock.
 */
package dim_ctrl_pkg;
    // ==========================================================
    // Clock and timing
    localparam int unsigned CORE_CLK_HZ = 40000000;
    localparam int unsigned MASTER_CLK_HZ = 16000000;
    localparam int unsigned PWM_DEFAULT_HZ = 888;
    localparam int unsigned PWM_MAX_HZ = 5300;
    localparam int unsigned RESET_HOLD_MS = 100;
    localparam int unsigned RESET_HOLD_CYC = CORE_CLK_HZ / 1000 * RESET_HOLD_MS;
    localparam int unsigned SYNC_IDLE_MS = 100;
    localparam int unsigned SYNC_IDLE_CYC = CORE_CLK_HZ / 1000 * SYNC_IDLE_MS;
    // Master tick: 16 MHz from 40 MHz by fractional accumulator (2/5)
    localparam logic [3:0] TICK_NUM = 4'h2;
    localparam logic [3:0] TICK_DEN = 4'h5;
    // Period in master ticks, 12-bit PWM is 4096 steps
    localparam logic [15:0] PERIOD_DEFAULT = 16'(MASTER_CLK_HZ / PWM_DEFAULT_HZ);
    localparam logic [15:0] PERIOD_MIN = 16'((MASTER_CLK_HZ + PWM_MAX_HZ - 1) / PWM_MAX_HZ);
    localparam int unsigned DUTY_W = 12;
    localparam int unsigned DIM_W = 10;
    localparam int unsigned ADC_W = 16;
    localparam int unsigned N_PWM = 3;
    localparam logic [11:0] DUTY_FULL = 12'hfff;
    // 10 % and 1 % of full scale
    localparam logic [11:0] DUTY_MIN_ANALOG = 12'h19a;
    localparam logic [11:0] DUTY_MIN_DIGITAL = 12'h029;
    // Channel stagger in master ticks
    localparam logic [15:0] STAGGER_TICKS = 16'h0008;

    // ==========================================================
    // Register map (word index on the plain port)
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_PERIOD = 4'h1;
    localparam logic [3:0] REG_NET_DIM = 4'h2;
    localparam logic [3:0] REG_STATUS = 4'h3;
    localparam logic [3:0] REG_DUTY1 = 4'h4;
    localparam logic [3:0] REG_ADC_X = 4'h5;
    localparam logic [3:0] REG_ADC_Y = 4'h6;
    localparam logic [3:0] REG_ADC_Z = 4'h7;
    localparam logic [3:0] REG_STRING = 4'h8;
    // CTRL fields
    localparam int unsigned CTRL_SRC_NET = 0;
    localparam int unsigned CTRL_SYNC_EN = 1;
    localparam int unsigned CTRL_AUX_DIG = 2;
    localparam int unsigned CTRL_AUX_CTL = 3;
    localparam int unsigned CTRL_SWAP = 4;
    localparam logic [7:0] CTRL_RESET = 8'h02;
    localparam logic [DIM_W-1:0] NET_DIM_RESET = 10'h3ff;
    localparam logic [9:0] AUX_ANALOG_THRESH = 10'h200;

    typedef enum logic [1:0] {
        MODE_ANALOG = 2'h0,
        MODE_DIGITAL = 2'h1,
        MODE_TUNE_ONLY = 2'h2
    } out_mode_t;
endpackage

// >>> design/adc_bank_if.sv
/*
 * Interface carrying the colour converter hand-off into the result bank.
 * Assumes one writer (the top) and one reader module.
 */
`timescale 1ns/1ps
interface adc_bank_if;
    logic done;
    logic [dim_ctrl_pkg::ADC_W-1:0] raw [3];
    logic [1:0] rd_sel;
    logic [dim_ctrl_pkg::ADC_W-1:0] rd_data;
    modport ctrl (output done, output raw, output rd_sel, input rd_data);
    modport bank (input done, input raw, input rd_sel, output rd_data);
endinterface

// >>> design/adc_result_bank.sv
/*
 * Double-buffered store of the three 16-bit converter results.
 * Assumes done is a one-cycle pulse on the core clock.
 */
`timescale 1ns/1ps
module adc_result_bank (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    adc_bank_if.bank bus
);
    logic [dim_ctrl_pkg::ADC_W-1:0] shadow_q [3];
    logic [dim_ctrl_pkg::ADC_W-1:0] rd_q;

    // All three words latched together on done, read from one register
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < 3; i++) shadow_q[i] <= '0;
        end else if (ce_i && bus.done) begin
            for (int i = 0; i < 3; i++) shadow_q[i] <= bus.raw[i];
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            rd_q <= '0;
        end else if (ce_i) begin
            rd_q <= (bus.rd_sel < 2'h3) ? shadow_q[bus.rd_sel] : '0;
        end
    end

    assign bus.rd_data = rd_q;
endmodule // adc_result_bank

// >>> verification/dim_ctrl_asserts.sv
/*
 * Port checks for the dimming output controller.
 * Assumes binding to the top module, one clock, synchronous reset.
 */
`timescale 1ns/1ps
module dim_ctrl_asserts #(
    parameter int unsigned RESET_HOLD_CYC = 50
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic mains_lock_and_reset_pin_i,
    input wire logic hv_supply_in_range_i,
    input wire logic primary_dim_output_pin_o,
    input wire logic [11:0] primary_analog_level_o,
    input wire logic primary_analog_en_o,
    input wire logic tune_a_pwm_o,
    input wire logic tune_b_pwm_o,
    input wire logic internal_divider_sel_o,
    input wire logic device_reset_o
);
    // ==========================================================
    // Cycles the raw pin has been low
    int unsigned low_cnt;
    always_ff @(posedge core_clk_i) begin
        if (rst_i || mains_lock_and_reset_pin_i) begin
            low_cnt <= 32'h0;
        end else if (low_cnt < 32'hffff) begin
            low_cnt <= low_cnt + 32'h1;
        end
    end

    // ==========================================================
    // Properties
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    a_period_floor: assert property (
        reg_rd_i && reg_addr_i == dim_ctrl_pkg::REG_PERIOD
        |=> reg_rdata_o >= dim_ctrl_pkg::PERIOD_MIN)
        else $error("period above maximum rate");
    a_stagger_ab: assert property (
        !($changed(tune_a_pwm_o) && $changed(tune_b_pwm_o)))
        else $error("tune outputs switched together");
    a_stagger_pa: assert property (
        !($changed(primary_dim_output_pin_o) && $changed(tune_a_pwm_o)))
        else $error("primary and tune a switched together");
    a_stagger_pb: assert property (
        !($changed(primary_dim_output_pin_o) && $changed(tune_b_pwm_o)))
        else $error("primary and tune b switched together");
    a_analog_floor: assert property (
        primary_analog_en_o |-> primary_analog_level_o >= dim_ctrl_pkg::DUTY_MIN_ANALOG)
        else $error("analog level under floor");
    a_mode_zero_quiet: assert property (
        primary_analog_en_o |-> !primary_dim_output_pin_o)
        else $error("primary pwm active in analog mode");
    a_divider_follow: assert property (
        $stable(hv_supply_in_range_i)[*6] |-> internal_divider_sel_o == hv_supply_in_range_i)
        else $error("divider select does not follow supply");
    a_reset_hold: assert property (
        $rose(device_reset_o) |-> $past(low_cnt, 3) + 4 >= RESET_HOLD_CYC)
        else $error("device reset before hold time");
    a_reset_fires: assert property (
        low_cnt == RESET_HOLD_CYC + 4 |-> ##[0:4] device_reset_o)
        else $error("device reset missing after long low");

    c_tune_edge: cover property ($rose(tune_a_pwm_o));
    c_analog: cover property (primary_analog_en_o);
    c_dev_reset: cover property ($rose(device_reset_o));
endmodule // dim_ctrl_asserts

// >>> verification/led_string_model.sv
/*
 * Far side: ballast input and two LED strings, counting on-time.
 * Assumes the bench frames each counting window with clr_i.
 */
`timescale 1ns/1ps
module led_string_model (
    input wire logic clk_i,
    input wire logic clr_i,
    input wire logic [2:0] pwm_i,
    output int unsigned on_cnt_o [3],
    output logic [1:0] string_cct_o
);
    // String a warm, string b cool
    assign string_cct_o = 2'h1;
    always_ff @(posedge clk_i) begin
        for (int k = 0; k < 3; k++) begin
            on_cnt_o[k] <= clr_i ? 32'h0 : on_cnt_o[k] + 32'(pwm_i[k]);
        end
    end
endmodule // led_string_model

// >>> verification/tb_lighting_dimming_output_ctrl.sv
/*
 * Self-checking bench for the dimming output controller.
 * Assumes package and design compiled first; hold counts shortened.
 */
`timescale 1ns/1ps
module tb_lighting_dimming_output_ctrl;
    localparam int unsigned HOLD = 50;
    localparam int unsigned PER = 7548;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [1:0] strap = 2'h1;
    logic pin = 1'b1;
    logic [9:0] dim_in = 10'h000;
    logic hv = 1'b0;
    logic done = 1'b0;
    logic [47:0] raw = 48'h0;
    logic aux_dig = 1'b1;
    logic clr = 1'b1;
    logic [15:0] rdata;
    logic [15:0] d;
    logic [1:0] cct;
    logic p_pin, p_en, ta, tbo, div_sel, dev_rst;
    logic [11:0] p_lvl;
    int unsigned cnt [3];
    int n_fail = 0;
    int checks_done = 0;

    lighting_dimming_output_ctrl #(.RESET_HOLD_CYC(HOLD), .SYNC_IDLE_CYC(HOLD))
    lighting_dimming_output_ctrl_i (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(1'b1),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .mode_strap_i(strap), .mains_lock_and_reset_pin_i(pin),
        .analog_dimmer_input_i(dim_in), .hv_supply_in_range_i(hv),
        .adc_done_i(done), .adc_raw_i(raw), .aux_digital_i(aux_dig),
        .aux_analog_i(10'h000), .string_cct_i(cct), .primary_dim_output_pin_o(p_pin),
        .primary_analog_level_o(p_lvl), .primary_analog_en_o(p_en),
        .tune_a_pwm_o(ta), .tune_b_pwm_o(tbo), .internal_divider_sel_o(div_sel),
        .device_reset_o(dev_rst)
    );

    led_string_model led_string_model_i (
        .clk_i(core_clk_i), .clr_i(clr), .pwm_i({tbo, ta, p_pin}),
        .on_cnt_o(cnt), .string_cct_o(cct)
    );

    initial begin
        forever #12.5 core_clk_i = ~core_clk_i;
    end

    // ==========================================================
    // Tasks
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic inr(input int unsigned v, input int unsigned lo, input int unsigned hi);
        chk(16'(v >= lo && v <= hi), 16'h0001);
    endtask

    task automatic wreg(input logic [3:0] a, input logic [15:0] v);
        @(posedge core_clk_i);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge core_clk_i);
        wr <= 1'b0;
    endtask

    task automatic rreg(input logic [3:0] a, output logic [15:0] v);
        @(posedge core_clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge core_clk_i);
        rd <= 1'b0;
        @(posedge core_clk_i);
        v = rdata;
    endtask

    task automatic rchk(input logic [3:0] a, input logic [15:0] exp);
        logic [15:0] v;
        rreg(a, v);
        chk(v, exp);
    endtask

    task automatic restart(input logic [1:0] m);
        strap <= m;
        rst_i <= 1'b1;
        repeat (6) @(posedge core_clk_i);
        rst_i <= 1'b0;
    endtask

    // Settle one period, then count on-time over one period
    task automatic measure();
        repeat (PER + 20) @(posedge core_clk_i);
        clr <= 1'b0;
        repeat (PER) @(posedge core_clk_i);
        clr <= 1'b1;
        @(posedge core_clk_i);
    endtask

    initial begin
        repeat (95000) @(posedge core_clk_i);
        n_fail++;
        close_out();
    end

    // ==========================================================
    // Tests
    initial begin
        restart(2'h1);
        rchk(dim_ctrl_pkg::REG_CTRL, 16'(dim_ctrl_pkg::CTRL_RESET));
        rchk(dim_ctrl_pkg::REG_NET_DIM, 16'(dim_ctrl_pkg::NET_DIM_RESET));
        rchk(dim_ctrl_pkg::REG_PERIOD, dim_ctrl_pkg::PERIOD_DEFAULT);
        wreg(dim_ctrl_pkg::REG_PERIOD, 16'h1000);
        rchk(dim_ctrl_pkg::REG_PERIOD, 16'h1000);
        wreg(dim_ctrl_pkg::REG_PERIOD, 16'h0001);
        rchk(dim_ctrl_pkg::REG_PERIOD, dim_ctrl_pkg::PERIOD_MIN);
        rchk(4'hf, 16'h0000);
        rchk(dim_ctrl_pkg::REG_STRING, 16'h0001);
        rreg(dim_ctrl_pkg::REG_STATUS, d);
        chk({12'h0, d[3:0]}, 16'h0009);
        $display("test registers done");

        @(posedge core_clk_i);
        raw <= 48'hc3c3_5a5a_1234;
        done <= 1'b1;
        repeat (6) @(posedge core_clk_i);
        raw <= 48'h0f0f_a5a5_edcb;
        for (int k = 0; k < 3; k++) begin
            rchk(4'(dim_ctrl_pkg::REG_ADC_X + k), 16'(48'hc3c3_5a5a_1234 >> (16 * k)));
        end
        rchk(dim_ctrl_pkg::REG_ADC_X, 16'h1234);
        done <= 1'b0;
        $display("test results done");

        wreg(dim_ctrl_pkg::REG_CTRL, 16'h0001);
        wreg(dim_ctrl_pkg::REG_NET_DIM, 16'h03ff);
        measure();
        inr(cnt[0], PER - 20, PER);
        inr(cnt[1], PER - 20, PER);
        inr(cnt[2], PER - 20, PER);
        wreg(dim_ctrl_pkg::REG_CTRL, 16'h0000);
        measure();
        inr(cnt[1], 0, 0);
        inr(cnt[2], 0, 0);
        inr(cnt[0], 55, 100);
        $display("test duty done");

        aux_dig <= 1'b0;
        wreg(dim_ctrl_pkg::REG_CTRL, 16'h000d);
        measure();
        inr(cnt[1], 0, 0);
        aux_dig <= 1'b1;
        repeat (8) @(posedge core_clk_i);
        rreg(dim_ctrl_pkg::REG_STATUS, d);
        chk({15'h0, d[5]}, 16'h0001);
        $display("test aux done");

        restart(2'h0);
        wreg(dim_ctrl_pkg::REG_PERIOD, 16'h0001);
        hv <= 1'b1;
        repeat (PER) @(posedge core_clk_i);
        chk({15'h0, p_en}, 16'h0001);
        chk({4'h0, p_lvl}, {4'h0, dim_ctrl_pkg::DUTY_MIN_ANALOG});
        chk({15'h0, div_sel}, 16'h0001);
        hv <= 1'b0;
        repeat (8) @(posedge core_clk_i);
        chk({15'h0, div_sel}, 16'h0000);
        $display("test analog mode done");

        restart(2'h2);
        wreg(dim_ctrl_pkg::REG_PERIOD, 16'h0001);
        dim_in <= 10'h3ff;
        measure();
        inr(cnt[0], 0, 0);
        inr(cnt[1], PER - 20, PER);
        chk({15'h0, p_en}, 16'h0000);
        rreg(dim_ctrl_pkg::REG_STATUS, d);
        chk({14'h0, d[1:0]}, 16'h0002);
        $display("test tune mode done");

        // Mains-like pulses, each far shorter than the hold time
        repeat (4) begin
            pin <= 1'b0;
            repeat (3) @(posedge core_clk_i);
            pin <= 1'b1;
            repeat (10) @(posedge core_clk_i);
        end
        rreg(dim_ctrl_pkg::REG_STATUS, d);
        chk({15'h0, d[4]}, 16'h0001);
        repeat (HOLD + 20) @(posedge core_clk_i);
        rreg(dim_ctrl_pkg::REG_STATUS, d);
        chk({15'h0, d[4]}, 16'h0000);
        $display("test sync done");

        pin <= 1'b0;
        repeat (HOLD - 20) @(posedge core_clk_i);
        chk({15'h0, dev_rst}, 16'h0000);
        repeat (30) @(posedge core_clk_i);
        chk({15'h0, dev_rst}, 16'h0001);
        pin <= 1'b1;
        $display("test long low done");
        close_out();
    end
endmodule // tb_lighting_dimming_output_ctrl

bind lighting_dimming_output_ctrl dim_ctrl_asserts #(.RESET_HOLD_CYC(RESET_HOLD_CYC))
dim_ctrl_asserts_i (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .mains_lock_and_reset_pin_i(mains_lock_and_reset_pin_i),
    .hv_supply_in_range_i(hv_supply_in_range_i),
    .primary_dim_output_pin_o(primary_dim_output_pin_o),
    .primary_analog_level_o(primary_analog_level_o),
    .primary_analog_en_o(primary_analog_en_o), .tune_a_pwm_o(tune_a_pwm_o),
    .tune_b_pwm_o(tune_b_pwm_o), .internal_divider_sel_o(internal_divider_sel_o),
    .device_reset_o(device_reset_o)
);
